// file: common/pcfc_defs.vh
`ifndef PCFC_DEFS_VH
`define PCFC_DEFS_VH

`define PCFC_COEF_W      16
`define PCFC_COEF_FRAC   12
`define PCFC_COEF_ONE    16'h1000
`define PCFC_NUM_COEF    12
`define PCFC_ACC_W       28
`define PCFC_ADDR_W      8

`define PCFC_OFF_COEF0   8'h00
`define PCFC_OFF_CTRL    8'h30
`define PCFC_OFF_STAT    8'h34

`define PCFC_WIDTH_8     2'h0
`define PCFC_WIDTH_16    2'h1
`define PCFC_WIDTH_24    2'h2
`define PCFC_WIDTH_32    2'h3
`define PCFC_CTRL_WIDTH  1:0
`define PCFC_CTRL_RESMP  2
`define PCFC_CTRL_RST    3'h2
`define PCFC_STAT_READY  16
`define PCFC_PAD_BYTE    8'h00
`define PCFC_IDX_BITS    5:2
`define PCFC_ALIGN_BITS  1:0
`define PCFC_CTRL_BITS   2:0
`define PCFC_COEF_BITS   15:0
`define PCFC_RDY_LIMIT   7'h0f

`define PCFC_FIFO_DEPTH  16
`define PCFC_FIFO_AW     4
`define PCFC_FIFO_W      34

`endif

// file: design/pcfc_top.v
`timescale 1ns/1ps
`default_nettype none
`include "pcfc_defs.vh"

// Plain synchronous FIFO; level lets the writer plan ahead of full.
module pcfc_fifo #(
	parameter WIDTH = 34,
	parameter DEPTH = 16,
	parameter AW    = 4
) (
	input  wire             pclk,
	input  wire             presetn,
	input  wire             wr_valid,
	output wire             wr_ready,
	input  wire [WIDTH-1:0] wr_data,
	output wire             rd_valid,
	input  wire             rd_ready,
	output wire [WIDTH-1:0] rd_data,
	output wire [AW:0]      level
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0]    wr_ptr_q;
	reg [AW-1:0]    rd_ptr_q;
	reg [AW:0]      count_q;
	wire            do_wr;
	wire            do_rd;

	// Full and empty come from the count, so they are exact every cycle.
	// A write offered while full is ignored; the caller must not rely on it.
	assign wr_ready = (count_q != DEPTH[AW:0]);
	assign rd_valid = (count_q != {(AW+1){1'b0}});
	assign rd_data  = mem[rd_ptr_q];
	assign level    = count_q;
	assign do_wr    = wr_valid & wr_ready;
	assign do_rd    = rd_valid & rd_ready;

	// Storage has no reset; only the pointers and the count matter.
	always @(posedge pclk) begin
		if (do_wr) begin
			mem[wr_ptr_q] <= wr_data;
		end
	end

	// Pointer and count update.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q  <= {(AW+1){1'b0}};
		end else begin
			if (do_wr) begin
				wr_ptr_q <= wr_ptr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			if (do_rd) begin
				rd_ptr_q <= rd_ptr_q + {{(AW-1){1'b0}}, 1'b1};
			end
			case ({do_wr, do_rd})
				2'b10: count_q <= count_q + {{AW{1'b0}}, 1'b1};
				2'b01: count_q <= count_q - {{AW{1'b0}}, 1'b1};
				default: count_q <= count_q;
			endcase
		end
	end
endmodule

// Colour matrix followed by pixel width packing, with an APB register file.
module pcfc_top (
	input  wire        pclk,
	input  wire        presetn,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	input  wire [23:0] s_axis_tdata,
	input  wire        s_axis_tvalid,
	output reg         s_axis_tready,
	input  wire        s_axis_tlast,
	input  wire        s_axis_tuser,
	output reg  [31:0] m_axis_tdata,
	output reg         m_axis_tvalid,
	input  wire        m_axis_tready,
	output reg         m_axis_tlast,
	output reg         m_axis_tuser
);
	reg [`PCFC_COEF_W-1:0] coef_q [0:`PCFC_NUM_COEF-1];
	reg [2:0]              ctrl_q;
	reg [15:0]             frames_q;
	reg                    frame_rdy_q;
	reg                    in_frame_q;
	reg                    a_vld_q;
	reg [23:0]             a_pix_q;
	reg                    a_last_q;
	reg                    a_user_q;
	reg                    b_vld_q;
	reg [31:0]             b_dat_q;
	reg                    b_last_q;
	reg                    b_user_q;
	reg                    phase_q;
	reg [7:0]              prev_g_q;
	reg [7:0]              prev_r_q;
	reg [31:0]             rd_d;
	reg                    err_d;
	reg [31:0]             pack_d;
	integer                i;
	wire                   s_acc;
	wire                   s_take;
	wire                   f_wr_ready;
	wire                   f_rd_valid;
	wire [33:0]            f_rd_data;
	wire [4:0]             f_level;
	wire                   f_pop;
	wire [6:0]             total;
	wire                   apb_setup;
	wire                   apb_wr;
	wire                   map_hit;
	wire [3:0]             coef_idx;
	wire [7:0]             o1;
	wire [7:0]             o2;
	wire [7:0]             o3;
	wire [8:0]             avg_g;
	wire [8:0]             avg_r;

	// Reset value of a coefficient: identity on c1, c5 and c9.
	function [`PCFC_COEF_W-1:0] coef_rst;
		input integer k;
		begin
			if (k == 0 || k == 4 || k == 8) begin
				coef_rst = `PCFC_COEF_ONE;
			end else begin
				coef_rst = {`PCFC_COEF_W{1'b0}};
			end
		end
	endfunction

	// One row of the matrix; the bias is scaled to full channel range.
	function [7:0] mrow;
		input [15:0] ca;
		input [15:0] cb;
		input [15:0] cc;
		input [15:0] cd;
		input [23:0] p;
		reg signed [`PCFC_ACC_W-1:0] acc;
		begin
			acc = $signed(ca) * $signed({1'b0, p[7:0]})
			    + $signed(cb) * $signed({1'b0, p[15:8]})
			    + $signed(cc) * $signed({1'b0, p[23:16]})
			    + $signed({cd, 8'h00});
			// Clamp before the shift so overflow cannot wrap.
			if (acc < 0) begin
				mrow = 8'h00;
			end else if (acc[`PCFC_ACC_W-2:`PCFC_COEF_FRAC] > 15'd255) begin
				mrow = 8'hff;
			end else begin
				mrow = acc[`PCFC_COEF_FRAC+7:`PCFC_COEF_FRAC];
			end
		end
	endfunction

	// Matrix rows read only the current pixel; no neighbour enters.
	assign o1 = mrow(coef_q[0], coef_q[1], coef_q[2], coef_q[9], a_pix_q);
	assign o2 = mrow(coef_q[3], coef_q[4], coef_q[5], coef_q[10], a_pix_q);
	assign o3 = mrow(coef_q[6], coef_q[7], coef_q[8], coef_q[11], a_pix_q);

	// Chroma average of this pixel and the previous one for 4:2:2.
	assign avg_g = {1'b0, o2} + {1'b0, prev_g_q};
	assign avg_r = {1'b0, o3} + {1'b0, prev_r_q};

	// Width packing; channel one sits in the low byte as blue.
	always @* begin
		pack_d = 32'h0000_0000;
		case (ctrl_q[`PCFC_CTRL_WIDTH])
			`PCFC_WIDTH_8: begin
				pack_d = {24'h00_0000, o1};
			end
			`PCFC_WIDTH_16: begin
				if (ctrl_q[`PCFC_CTRL_RESMP]) begin
					pack_d = {16'h0000, (phase_q ? avg_r[8:1] : avg_g[8:1]), o1};
				end else begin
					pack_d = {16'h0000, o2, o1};
				end
			end
			`PCFC_WIDTH_24: begin
				pack_d = {8'h00, o3, o2, o1};
			end
			default: begin
				pack_d = {`PCFC_PAD_BYTE, o3, o2, o1};
			end
		endcase
	end

	// Pixels before a start of frame are taken and dropped so only whole frames go out.
	assign s_acc  = s_axis_tvalid & s_axis_tready;
	assign s_take = s_acc & (in_frame_q | s_axis_tuser);

	// Words in flight are counted so the FIFO can never overflow.
	assign total = {2'b00, f_level} + {6'h00, a_vld_q} + {6'h00, b_vld_q}
	             + {6'h00, s_acc};

	// Input gate, matrix stage and packing stage.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_axis_tready <= 1'b0;
			in_frame_q    <= 1'b0;
			a_vld_q       <= 1'b0;
			a_pix_q       <= 24'h00_0000;
			a_last_q      <= 1'b0;
			a_user_q      <= 1'b0;
			b_vld_q       <= 1'b0;
			b_dat_q       <= 32'h0000_0000;
			b_last_q      <= 1'b0;
			b_user_q      <= 1'b0;
			phase_q       <= 1'b0;
			prev_g_q      <= 8'h00;
			prev_r_q      <= 8'h00;
		end else begin
			// Ready is withdrawn early enough for the two stages in flight.
			s_axis_tready <= f_wr_ready & (total < `PCFC_RDY_LIMIT);
			// A one-beat frame has both marks; the end must win.
			if (s_acc & s_axis_tlast) begin
				in_frame_q <= 1'b0;
			end else if (s_acc & s_axis_tuser) begin
				in_frame_q <= 1'b1;
			end
			a_vld_q  <= s_take;
			a_pix_q  <= s_axis_tdata;
			a_last_q <= s_axis_tlast;
			a_user_q <= s_axis_tuser;
			b_vld_q  <= a_vld_q;
			// History and phase move only on real pixels.
			if (a_vld_q) begin
				b_dat_q  <= pack_d;
				b_last_q <= a_last_q;
				b_user_q <= a_user_q;
				prev_g_q <= o2;
				prev_r_q <= o3;
				phase_q  <= a_last_q ? 1'b0 : ~phase_q;
			end
		end
	end

	pcfc_fifo #(
		.WIDTH (`PCFC_FIFO_W),
		.DEPTH (`PCFC_FIFO_DEPTH),
		.AW    (`PCFC_FIFO_AW)
	) u_fifo (
		.pclk     (pclk),
		.presetn  (presetn),
		.wr_valid (b_vld_q),
		.wr_ready (f_wr_ready),
		.wr_data  ({b_user_q, b_last_q, b_dat_q}),
		.rd_valid (f_rd_valid),
		.rd_ready (f_pop),
		.rd_data  (f_rd_data),
		.level    (f_level)
	);

	// Output register refills whenever it is empty or being taken.
	assign f_pop = ~m_axis_tvalid | m_axis_tready;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			m_axis_tvalid <= 1'b0;
			m_axis_tdata  <= 32'h0000_0000;
			m_axis_tlast  <= 1'b0;
			m_axis_tuser  <= 1'b0;
		end else if (f_pop) begin
			m_axis_tvalid <= f_rd_valid;
			if (f_rd_valid) begin
				m_axis_tdata <= f_rd_data[31:0];
				m_axis_tlast <= f_rd_data[32];
				m_axis_tuser <= f_rd_data[33];
			end
		end
	end

	// APB decode; the answer is prepared in setup so access needs no wait.
	assign apb_setup = psel & ~penable;
	assign apb_wr    = psel & penable & pready & pwrite;
	assign coef_idx  = paddr[`PCFC_IDX_BITS];
	assign map_hit   = (paddr[`PCFC_ALIGN_BITS] == 2'b00) &&
	                   (paddr <= `PCFC_OFF_STAT);

	always @* begin
		rd_d  = 32'h0000_0000;
		err_d = ~map_hit;
		if (paddr == `PCFC_OFF_CTRL) begin
			rd_d = {29'h0000_0000, ctrl_q};
		end else if (paddr == `PCFC_OFF_STAT) begin
			rd_d = {15'h0000, frame_rdy_q, frames_q};
		end else if (map_hit) begin
			rd_d = {{16{coef_q[coef_idx][15]}}, coef_q[coef_idx]};
		end
	end

	// Registers change at the access edge, so settings apply at run time.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
			ctrl_q  <= `PCFC_CTRL_RST;
			for (i = 0; i < `PCFC_NUM_COEF; i = i + 1) begin
				coef_q[i] <= coef_rst(i);
			end
		end else begin
			pready  <= apb_setup;
			pslverr <= apb_setup & err_d;
			prdata  <= apb_setup ? rd_d : 32'h0000_0000;
			// A refused access leaves every register alone.
			if (apb_wr & map_hit) begin
				if (paddr == `PCFC_OFF_CTRL) begin
					ctrl_q <= pwdata[`PCFC_CTRL_BITS];
				end else if (paddr < `PCFC_OFF_CTRL) begin
					coef_q[coef_idx] <= pwdata[`PCFC_COEF_BITS];
				end
			end
		end
	end

	// Frame counter and sticky ready flag; a new frame end beats a clear.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frames_q    <= 16'h0000;
			frame_rdy_q <= 1'b0;
		end else begin
			// Counted at the last beat's handshake, not before.
			if (m_axis_tvalid & m_axis_tready & m_axis_tlast) begin
				frames_q    <= frames_q + 16'h0001;
				frame_rdy_q <= 1'b1;
			end else if (apb_wr && paddr == `PCFC_OFF_STAT &&
			             pwdata[`PCFC_STAT_READY]) begin
				frame_rdy_q <= 1'b0;
			end
		end
	end
endmodule

`default_nettype wire

// file: tb/pcfc_checker.sv
`timescale 1ns/1ps
`default_nettype none
// Watches the register port and the packed output stream of the block.
module pcfc_checker (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic [31:0] m_axis_tdata,
	input wire logic        m_axis_tvalid,
	input wire logic        m_axis_tready
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// An access always opens with a setup cycle; a stall is valid unanswered.
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_stall;
		m_axis_tvalid && !m_axis_tready;
	endsequence
	a_apb_ready_setup: assert property (s_setup |=> pready)
		else $error("no answer after setup");
	a_apb_ready_only: assert property (pready |-> psel && penable)
		else $error("answer outside access");
	a_apb_ready_pulse: assert property (pready |=> !pready)
		else $error("answer longer than one cycle");
	a_apb_err_bad: assert property (s_setup ##0
		(paddr[1:0] != 2'h0 || paddr > 8'h34) |=> pslverr)
		else $error("bad address not refused");
	a_apb_err_good: assert property (s_setup ##0
		(paddr[1:0] == 2'h0 && paddr <= 8'h34) |=> !pslverr)
		else $error("good address refused");
	a_prdata_idle: assert property (!pready |-> prdata == 32'h0)
		else $error("read data outside access");
	// Held data under backpressure keeps pixels from being lost or doubled.
	a_axis_hold_data: assert property (s_stall |=>
		m_axis_tvalid && $stable(m_axis_tdata))
		else $error("output changed while stalled");
	a_axis_pad_zero: assert property (m_axis_tvalid |->
		m_axis_tdata[31:24] == 8'h00)
		else $error("pad byte not zero");
endmodule
bind pcfc_top pcfc_checker chk_u (.pclk, .presetn, .psel, .penable, .paddr,
	.prdata, .pready, .pslverr, .m_axis_tdata, .m_axis_tvalid, .m_axis_tready);
`default_nettype wire

// file: tb/pcfc_sink.sv
`timescale 1ns/1ps
`default_nettype none
// Frame buffer writer model: always takes, stalls one cycle in four, or stops.
module pcfc_sink (
	input wire logic       pclk,
	input wire logic       presetn,
	input wire logic [1:0] mode,
	output logic           tready
);
	logic [1:0] cnt_q;
	// Free running phase counter for the stall pattern.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cnt_q <= 2'h0;
		else
			cnt_q <= cnt_q + 2'h1;
	end
	// Ready may move without valid, as a real writer's does.
	assign tready = (mode == 2'h0) || (mode == 2'h1 && cnt_q != 2'h3);
endmodule
`default_nettype wire

// file: tb/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "pcfc_defs.vh"
module tb;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd, m_axis_tdata;
	logic [23:0] s_axis_tdata;
	logic        s_axis_tvalid, s_axis_tready, s_axis_tlast, s_axis_tuser;
	logic        m_axis_tvalid, m_axis_tready, m_axis_tlast, m_axis_tuser;
	logic [1:0]  mode;
	logic [33:0] exp_q [$];
	int          err_count, n_tests, i;
	logic [15:0] coef [12] = '{16'h0000, 16'h0000, 16'h1000, 16'h0000,
		16'h1000, 16'h0000, 16'h1000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'he000};
	logic [31:0] wexp [4] = '{32'h0000_0010, 32'h0000_2010, 32'h0030_2010,
		32'h0030_2010};

	pcfc_top dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .s_axis_tdata, .s_axis_tvalid,
		.s_axis_tready, .s_axis_tlast, .s_axis_tuser, .m_axis_tdata,
		.m_axis_tvalid, .m_axis_tready, .m_axis_tlast, .m_axis_tuser);
	pcfc_sink snk_u (.pclk, .presetn, .mode, .tready(m_axis_tready));

	// Clock at 40 MHz.
	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	task end_sim;
		$display("checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_tests++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task hang(input string nm);
		err_count++;
		$display("[ERR] %s exp handshake got timeout", nm);
		end_sim;
	endtask

	// One register access; entered and left just after a rising edge.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 20; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 20) hang("pready");
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task rchk(input logic [7:0] a, input logic [31:0] e, input logic ee);
		apb(1'b0, a, 32'h0);
		chk("rdata", {2'h0, e}, {2'h0, rd});
		chk("slverr", {33'h0, ee}, {33'h0, er});
	endtask

	// Valid stays up between beats so a frame's beats go back to back; it drops after the last beat.
	task put(input logic [23:0] d, input logic u, input logic l);
		int k;
		s_axis_tvalid <= 1'b1;
		s_axis_tdata <= d;
		s_axis_tuser <= u;
		s_axis_tlast <= l;
		for (k = 0; k < 50; k++) begin
			@(posedge pclk);
			if (s_axis_tready === 1'b1) break;
		end
		if (k == 50) hang("tready");
		if (l) s_axis_tvalid <= 1'b0;
	endtask

	task drain;
		int k;
		for (k = 0; k < 400; k++) begin
			@(posedge pclk);
			if (exp_q.size() == 0) break;
		end
		if (k == 400) hang("drain");
		repeat (8) @(posedge pclk);
	endtask

	// Every output beat, with its frame marks, must be the next expected.
	always @(posedge pclk) begin
		if (presetn && m_axis_tvalid && m_axis_tready) begin
			if (exp_q.size() == 0)
				hang("beat");
			else
				chk("beat", exp_q.pop_front(),
					{m_axis_tuser, m_axis_tlast, m_axis_tdata});
		end
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, mode, presetn} = '0;
		{s_axis_tdata, s_axis_tvalid, s_axis_tlast, s_axis_tuser} = '0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rchk(`PCFC_OFF_CTRL, 32'h0000_0002, 1'b0);
		rchk(`PCFC_OFF_COEF0, 32'h0000_1000, 1'b0);
		rchk(8'h04, 32'h0, 1'b0);
		rchk(8'h38, 32'h0, 1'b1);
		rchk(8'h31, 32'h0, 1'b1);
		apb(1'b1, 8'h00, 32'h0000_e000);
		rchk(8'h00, 32'hffff_e000, 1'b0);
		apb(1'b1, 8'h00, 32'h0000_1000);
		$display("test registers done");
		// Each width setting on a one pixel frame, then chroma resampling.
		for (i = 0; i < 4; i++) begin
			apb(1'b1, `PCFC_OFF_CTRL, 32'(i));
			exp_q.push_back({2'h3, wexp[i]});
			put(24'h30_2010, 1'b1, 1'b1);
			drain;
		end
		apb(1'b1, `PCFC_OFF_CTRL, 32'h0000_0005);
		exp_q.push_back({2'h2, 32'h0000_2010});
		exp_q.push_back({2'h1, 32'h0000_4010});
		put(24'h00_0077, 1'b0, 1'b0);
		put(24'h30_2010, 1'b1, 1'b0);
		put(24'h50_4010, 1'b0, 1'b1);
		drain;
		// Five whole frames went out; the ready flag clears on a one.
		rchk(`PCFC_OFF_STAT, 32'h0001_0005, 1'b0);
		apb(1'b1, `PCFC_OFF_STAT, 32'h0001_0000);
		rchk(`PCFC_OFF_STAT, 32'h0000_0005, 1'b0);
		$display("test widths done");
		// Channel swap with a saturating offset while the FIFO fills.
		apb(1'b1, `PCFC_OFF_CTRL, 32'h0000_0002);
		for (i = 0; i < 12; i++)
			apb(1'b1, 8'(4 * i), {16'h0, coef[i]});
		mode <= 2'h2;
		put(24'h11_1111, 1'b0, 1'b0);
		for (i = 0; i < 20; i++) begin
			if (i == 16) begin
				s_axis_tvalid <= 1'b0;
				repeat (6) @(posedge pclk);
				chk("full", 34'h0, {33'h0, s_axis_tready});
				mode <= 2'h1;
			end
			exp_q.push_back({i == 0, i == 19, 16'h0, 8'h20 + 8'(i),
				8'h30 + 8'(i)});
			put(24'h30_2010 + 24'(i) * 24'h01_0101, i == 0, i == 19);
		end
		drain;
		rchk(`PCFC_OFF_STAT, 32'h0001_0006, 1'b0);
		$display("test matrix and backpressure done");
		end_sim;
	end
endmodule
`default_nettype wire
